// *** hdl/mhsl_link.sv ***
`timescale 1ns/1ps
// Behaviour
// - drive data-ready low when setup enables it
// - abandon partial command after 10 ms
// - receive time-out sets uninitialized flag
// - purge low resets link and its buffers
// - purge leaves metering running
// - status reads queued, up to four waiting, each one answered
// - status answer held during post-processing
// - data-ready pulses only when mask ready set
// - indications continue only after energy reads
// - compensation uses nominal temperature reference
// - status reports overflow, uninitialized and events
// - hardware reset low forces full reset
// - rate and pulse polarity from select inputs
// - interval is count times 42 over 2520.6 Hz
// - unread energy overwritten at interval end
// - link usable within 20 ms of purge
module mhsl_link
  import mhsl_pkg::*;
#(
  parameter int RX_TO_CYC = RX_TIMEOUT_CYC,
  parameter int IVL_CYC   = IVL_UNIT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        hardwareResetLow,
  input  wire logic        linkPurgeLow,
  input  wire logic        rateSelectInput,
  input  wire logic        pulseInitInput,
  input  wire logic        rxd,
  output logic             txd,
  output logic             dataReadyLow,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic  [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] energyIn,
  input  wire logic        overflowEvt,
  input  wire logic  [4:0] meterEvt,
  input  wire logic        postBusy,
  input  wire logic [15:0] rawTemp,
  output logic      [31:0] setupWord,
  output logic      [15:0] tempOffset,
  output logic             pulsePolarity
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic         rstAll;
  logic         linkRst;
  logic         rateSel_q;
  logic  [7:0]  status_q;
  logic  [7:0]  mask_q;
  logic [15:0]  nomTemp_q;
  logic [15:0]  interval_q;
  logic [31:0]  energy_q;
  logic         armed_q;
  logic [31:0]  unitCnt_q;
  logic [15:0]  ivlCnt_q;
  logic         intervalEnd;
  logic         apbAcc;
  logic         apbWr;
  logic         apbEnergyRd;
  logic         uWr;
  logic         wrEn;
  logic  [7:0]  wrAddr;
  logic [31:0]  wrData;
  logic         energyRead;
  logic  [7:0]  rxByte;
  logic         rxValid;
  logic         txBusy;
  logic         txStart_q;
  logic  [7:0]  txByte_q;
  mhsl_pstate_t pState_q;
  logic  [5:0]  cmdIdx_q;
  logic  [1:0]  dCnt_q;
  logic [31:0]  wBuf_q;
  logic [31:0]  toCnt_q;
  logic         rxTimeout;
  logic  [5:0]  rq_q [QDEPTH];
  logic  [1:0]  rqWp_q;
  logic  [1:0]  rqRp_q;
  logic  [2:0]  rqCnt_q;
  logic         rqPush;
  logic         rqPop;
  mhsl_rstate_t rState_q;
  logic  [7:0]  respAddr_q;
  logic [31:0]  respWord_q;
  logic  [1:0]  respByte_q;
  logic         respLoad;
  logic  [7:0]  status_d;

  // hardware reset acts like the system reset; purge only touches the link
  assign rstAll  = sys_rst || !hardwareResetLow;
  assign linkRst = rstAll || !linkPurgeLow;

  // ----------------------------------------------------------------------
  // register decode shared by bus and serial commands
  // ----------------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] a);
    return a == A_ENERGY || a == A_STATUS || a == A_MASK ||
           a == A_SETUP || a == A_NOMTEMP || a == A_INTERVAL;
  endfunction

  function automatic logic [31:0] rdSel(input logic [7:0] a);
    case (a)
      A_ENERGY:   return energy_q;
      A_STATUS:   return {24'h000000, status_q};
      A_MASK:     return {24'h000000, mask_q};
      A_SETUP:    return setupWord;
      A_NOMTEMP:  return {16'h0000, nomTemp_q};
      A_INTERVAL: return {16'h0000, interval_q};
      default:    return 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // ----------------------------------------------------------------------
  assign apbAcc      = psel && penable && !pready;
  assign apbWr       = psel && penable && pready && pwrite && isMapped(paddr);
  assign apbEnergyRd = psel && penable && pready && !pwrite && paddr == A_ENERGY;

  always_ff @(posedge mclk) begin
    if (rstAll) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= apbAcc;
      pslverr <= apbAcc && !isMapped(paddr);
      if (apbAcc) begin
        prdata <= rdSel(paddr);
      end
    end
  end

  // bus writes win; a serial write waits in P_WRITE for a free cycle
  assign uWr        = pState_q == P_WRITE && !apbWr;
  assign wrEn       = apbWr || uWr;
  assign wrAddr     = apbWr ? paddr : {cmdIdx_q, 2'b00};
  assign wrData     = apbWr ? pwdata : wBuf_q;
  assign energyRead = apbEnergyRd || (respLoad && respAddr_q == A_ENERGY);

  // ----------------------------------------------------------------------
  // configuration registers and strap capture
  // ----------------------------------------------------------------------
  // rate strap follows its pin while held in reset or purge, pulse strap only in reset; frozen after
  always_ff @(posedge mclk) begin
    if (ce && linkRst) begin
      rateSel_q <= rateSelectInput;
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAll) begin
      pulsePolarity <= pulseInitInput;
      mask_q        <= MASK_RST;
      setupWord     <= SETUP_RST;
      nomTemp_q     <= NOMTEMP_RST;
      interval_q    <= INTERVAL_RST;
    end else if (ce && wrEn) begin
      case (wrAddr)
        A_MASK:    mask_q    <= wrData[7:0];
        A_SETUP:   setupWord <= wrData;
        A_NOMTEMP: nomTemp_q <= wrData[15:0];
        // a zero length would wrap the compare to a 65536-count interval, so it is ignored
        A_INTERVAL: begin
          if (wrData[15:0] != 16'h0000) begin
            interval_q <= wrData[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  // compensation term handed to the metering engine
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      tempOffset <= 16'h0000;
    end else if (ce) begin
      tempOffset <= rawTemp - nomTemp_q;
    end
  end

  // ----------------------------------------------------------------------
  // accumulation interval timer
  // ----------------------------------------------------------------------
  assign intervalEnd = setupWord[SU_CE_EN] && unitCnt_q == 32'(IVL_CYC - 1) &&
                       ivlCnt_q == interval_q - 16'h0001;

  always_ff @(posedge mclk) begin
    if (rstAll || !setupWord[SU_CE_EN]) begin
      unitCnt_q <= 32'h0000_0000;
      ivlCnt_q  <= 16'h0000;
    end else if (ce) begin
      if (unitCnt_q == 32'(IVL_CYC - 1)) begin
        unitCnt_q <= 32'h0000_0000;
        ivlCnt_q  <= intervalEnd ? 16'h0000 : ivlCnt_q + 16'h0001;
      end else begin
        unitCnt_q <= unitCnt_q + 32'h0000_0001;
      end
    end
  end

  // fresh value replaces the old one whether it was read or not
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      energy_q <= 32'h0000_0000;
    end else if (ce && intervalEnd) begin
      energy_q <= energyIn;
    end
  end

  // ----------------------------------------------------------------------
  // status word: sticky, write one to clear, set beats clear
  // ----------------------------------------------------------------------
  always_comb begin
    status_d = status_q;
    if (wrEn && wrAddr == A_STATUS) begin
      status_d = status_d & ~wrData[7:0];
    end
    if (energyRead) begin
      status_d[ST_READY] = 1'b0;
    end
    status_d[ST_READY]  = status_d[ST_READY] | intervalEnd;
    status_d[ST_UNINIT] = status_d[ST_UNINIT] | rxTimeout;
    status_d[ST_OVF]    = status_d[ST_OVF] | overflowEvt;
    status_d[ST_EVT_LSB +: ST_EVT_N] = status_d[ST_EVT_LSB +: ST_EVT_N] | meterEvt;
  end

  always_ff @(posedge mclk) begin
    if (rstAll) begin
      status_q <= STATUS_RST;
    end else if (ce) begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------------
  // data-ready output
  // ----------------------------------------------------------------------
  // armed only by an energy read, so a host that stops reading sees no more
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      dataReadyLow <= 1'b1;
      armed_q      <= 1'b0;
    end else if (ce) begin
      if (energyRead) begin
        dataReadyLow <= 1'b1;
        armed_q      <= 1'b1;
      end else if (intervalEnd && armed_q && mask_q[ST_READY] && setupWord[SU_DRDY_EN]) begin
        dataReadyLow <= 1'b0;
        armed_q      <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------------
  mhsl_uart u_uart (
    .mclk    (mclk),
    .ce      (ce),
    .rst     (linkRst),
    .divisor (rateSel_q ? DIV_HI : DIV_LO),
    .rxd     (rxd),
    .rxByte  (rxByte),
    .rxValid (rxValid),
    .txStart (txStart_q),
    .txByte  (txByte_q),
    .txBusy  (txBusy),
    .txd     (txd)
  );

  // command parser: a read is one byte, a write is five
  assign rqPush = pState_q == P_IDLE && rxValid && !rxByte[CMD_WR_BIT];

  always_ff @(posedge mclk) begin
    if (linkRst) begin
      pState_q <= P_IDLE;
      cmdIdx_q <= 6'h00;
      dCnt_q   <= 2'h0;
      wBuf_q   <= 32'h0000_0000;
    end else if (ce) begin
      case (pState_q)
        P_IDLE: begin
          if (rxValid) begin
            cmdIdx_q <= rxByte[5:0];
            dCnt_q   <= 2'h0;
            if (rxByte[CMD_WR_BIT]) begin
              pState_q <= P_DATA;
            end
          end
        end
        P_DATA: begin
          if (rxTimeout) begin
            pState_q <= P_IDLE;
          end else if (rxValid) begin
            wBuf_q <= {wBuf_q[23:0], rxByte};
            dCnt_q <= dCnt_q + 2'h1;
            if (dCnt_q == 2'h3) begin
              pState_q <= P_WRITE;
            end
          end
        end
        P_WRITE: begin
          if (uWr) begin
            pState_q <= P_IDLE;
          end
        end
        default: pState_q <= P_IDLE;
      endcase
    end
  end

  // idle gap counter, only live inside a partial command
  assign rxTimeout = pState_q == P_DATA && toCnt_q == 32'(RX_TO_CYC - 1) && !rxValid;

  always_ff @(posedge mclk) begin
    if (linkRst || pState_q != P_DATA || rxValid) begin
      toCnt_q <= 32'h0000_0000;
    end else if (ce && !rxTimeout) begin
      toCnt_q <= toCnt_q + 32'h0000_0001;
    end
  end

  // read queue: each accepted read, status included, gets its own answer
  // a fifth read while four wait is dropped; the host must not stack so deep
  assign rqPop = rState_q == R_IDLE && rqCnt_q != 3'h0;

  always_ff @(posedge mclk) begin
    if (linkRst) begin
      rqWp_q  <= 2'h0;
      rqRp_q  <= 2'h0;
      rqCnt_q <= 3'h0;
    end else if (ce) begin
      if (rqPush && rqCnt_q != 3'(QDEPTH)) begin
        rq_q[rqWp_q] <= rxByte[5:0];
        rqWp_q       <= rqWp_q + 2'h1;
      end
      if (rqPop) begin
        rqRp_q <= rqRp_q + 2'h1;
      end
      rqCnt_q <= rqCnt_q + 3'((rqPush && rqCnt_q != 3'(QDEPTH)) ? 1 : 0) - 3'(rqPop ? 1 : 0);
    end
  end

  // response engine: status answers wait out post-processing
  assign respLoad = ce && rState_q == R_WAIT && !(respAddr_q == A_STATUS && postBusy);

  always_ff @(posedge mclk) begin
    if (linkRst) begin
      rState_q   <= R_IDLE;
      respAddr_q <= 8'h00;
      respWord_q <= 32'h0000_0000;
      respByte_q <= 2'h0;
      txStart_q  <= 1'b0;
      txByte_q   <= 8'h00;
    end else if (ce) begin
      txStart_q <= 1'b0;
      case (rState_q)
        R_IDLE: begin
          if (rqPop) begin
            respAddr_q <= {rq_q[rqRp_q], 2'b00};
            rState_q   <= R_WAIT;
          end
        end
        R_WAIT: begin
          if (respLoad) begin
            respWord_q <= rdSel(respAddr_q);
            respByte_q <= 2'h0;
            rState_q   <= R_SEND;
          end
        end
        R_SEND: begin
          if (!txBusy && !txStart_q) begin
            txStart_q  <= 1'b1;
            txByte_q   <= respWord_q[31:24];
            respWord_q <= {respWord_q[23:0], 8'h00};
            respByte_q <= respByte_q + 2'h1;
            if (respByte_q == 2'h3) begin
              rState_q <= R_IDLE;
            end
          end
        end
        default: rState_q <= R_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rstAll);

  sequence s_timeout_hit;
    ce && rxTimeout;
  endsequence
  sequence s_drdy_fall;
    $fell(dataReadyLow);
  endsequence

  a_timeout_uninit: assert property (s_timeout_hit |=> status_q[ST_UNINIT] && pState_q == P_IDLE)
    else $error("time-out did not flag uninitialized");
  a_timeout_bound: assert property (toCnt_q < 32'(RX_TO_CYC))
    else $error("time-out counter ran past its limit");
  a_rx_restart: assert property (ce && rxValid && pState_q == P_DATA |=> toCnt_q == 32'h0)
    else $error("received byte did not restart time-out");
  a_drdy_gate: assert property (s_drdy_fall |-> $past(mask_q[ST_READY]) && $past(setupWord[SU_DRDY_EN]))
    else $error("data-ready fell without mask and setup enable");
  a_drdy_armed: assert property (s_drdy_fall |-> $past(armed_q) && $past(intervalEnd))
    else $error("data-ready fell without prior energy read");
  a_drdy_release: assert property (ce && energyRead |=> dataReadyLow)
    else $error("energy read did not release data-ready");
  a_purge_clear: assert property (ce && !linkPurgeLow |=> pState_q == P_IDLE && rqCnt_q == 3'h0 && !txBusy)
    else $error("purge left link state behind");
  a_post_hold: assert property (respLoad && respAddr_q == A_STATUS |-> !postBusy)
    else $error("status answered during post-processing");
  a_energy_latch: assert property (ce && intervalEnd |=> energy_q == $past(energyIn))
    else $error("interval end did not take new energy");
  a_apb_one: assert property (pready |=> !pready)
    else $error("bus ready held for more than one cycle");

endmodule

// *** hdl/mhsl_pkg.sv ***
package mhsl_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ            = 25_000_000;
  localparam int          RX_TIMEOUT_MS     = 10;          // nominal abandon time
  localparam int          RX_TIMEOUT_MAX_MS = 20;          // longest allowed
  localparam int          RX_TIMEOUT_CYC    = (CLK_HZ / 1000) * RX_TIMEOUT_MS;
  localparam longint      IVL_MULT          = 42;          // per length count
  localparam longint      IVL_REF_DHZ       = 25206;       // 2520.6 Hz in tenths
  localparam int          IVL_UNIT_CYC      = int'((longint'(CLK_HZ) * IVL_MULT * 64'd10) / IVL_REF_DHZ);

  // serial rates, picked by the rate select strap
  localparam int          RATE_LO_BAUD      = 9600;
  localparam int          RATE_HI_BAUD      = 38400;
  localparam logic [11:0] DIV_LO            = 12'(CLK_HZ / RATE_LO_BAUD);
  localparam logic [11:0] DIV_HI            = 12'(CLK_HZ / RATE_HI_BAUD);

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  A_ENERGY          = 8'h00;
  localparam logic [7:0]  A_STATUS          = 8'h04;
  localparam logic [7:0]  A_MASK            = 8'h08;
  localparam logic [7:0]  A_SETUP           = 8'h0c;
  localparam logic [7:0]  A_NOMTEMP         = 8'h10;
  localparam logic [7:0]  A_INTERVAL        = 8'h14;

  // status word / status interrupt mask bits
  localparam int          ST_READY          = 0;
  localparam int          ST_UNINIT         = 1;
  localparam int          ST_OVF            = 2;
  localparam int          ST_EVT_LSB        = 3;   // sag, creep, over-v, over-i, pin change
  localparam int          ST_EVT_N          = 5;
  localparam logic [7:0]  STATUS_RST        = 8'h02;
  localparam logic [7:0]  MASK_RST          = 8'h00;

  // setup word fields
  localparam int          SU_CE_EN          = 4;
  localparam int          SU_DRDY_EN        = 9;
  localparam int          SU_EQU_LSB        = 5;
  localparam int          SU_IMG_LSB        = 22;
  localparam int          SU_RATE_LSB       = 25;
  localparam logic [31:0] SETUP_RST         = 32'h0000_0000;
  localparam logic [15:0] INTERVAL_RST      = 16'h003c;   // 60 counts
  localparam logic [15:0] NOMTEMP_RST       = 16'h0000;

  // serial command byte: bit 7 write, bits 5:0 word index
  localparam int          CMD_WR_BIT        = 7;
  localparam int          QDEPTH            = 4;

  typedef enum logic [2:0] {
    P_IDLE  = 3'b001,
    P_DATA  = 3'b010,
    P_WRITE = 3'b100
  } mhsl_pstate_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'b001,
    R_WAIT = 3'b010,
    R_SEND = 3'b100
  } mhsl_rstate_t;

endpackage

// *** hdl/mhsl_uart.sv ***
`timescale 1ns/1ps
module mhsl_uart
  import mhsl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        ce,
  input  wire logic        rst,
  input  wire logic [11:0] divisor,
  input  wire logic        rxd,
  output logic       [7:0] rxByte,
  output logic             rxValid,
  input  wire logic        txStart,
  input  wire logic  [7:0] txByte,
  output logic             txBusy,
  output logic             txd
);

  logic        rxAct_q;
  logic [11:0] rxCnt_q;
  logic  [3:0] rxBit_q;
  logic  [7:0] rxSh_q;
  logic  [9:0] txSh_q;
  logic [11:0] txCnt_q;
  logic  [3:0] txBit_q;

  // ----------------------------------------------------------------------
  // receiver: 8N1, sampled mid-bit
  // ----------------------------------------------------------------------
  // a start bit that is high again at mid-bit is a glitch and is dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxAct_q <= 1'b0;
      rxCnt_q <= 12'h000;
      rxBit_q <= 4'h0;
      rxSh_q  <= 8'h00;
      rxByte  <= 8'h00;
      rxValid <= 1'b0;
    end else if (ce) begin
      rxValid <= 1'b0;
      if (!rxAct_q) begin
        if (!rxd) begin
          rxAct_q <= 1'b1;
          rxCnt_q <= divisor >> 1;
          rxBit_q <= 4'h0;
        end
      end else if (rxCnt_q != 12'h000) begin
        rxCnt_q <= rxCnt_q - 12'h001;
      end else begin
        rxCnt_q <= divisor - 12'h001;
        rxBit_q <= rxBit_q + 4'h1;
        if (rxBit_q == 4'h0 && rxd) begin
          rxAct_q <= 1'b0;
        end else if (rxBit_q == 4'h9) begin
          rxAct_q <= 1'b0;
          rxValid <= rxd;                 // framing error drops the byte
          rxByte  <= rxSh_q;
        end else if (rxBit_q != 4'h0) begin
          rxSh_q  <= {rxd, rxSh_q[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter: start, eight data lsb first, stop
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      txBusy  <= 1'b0;
      txd     <= 1'b1;
      txSh_q  <= 10'h3ff;
      txCnt_q <= 12'h000;
      txBit_q <= 4'h0;
    end else if (ce) begin
      if (!txBusy) begin
        txd <= 1'b1;
        if (txStart) begin
          txBusy  <= 1'b1;
          txSh_q  <= {1'b1, txByte, 1'b0};
          txCnt_q <= 12'h000;
          txBit_q <= 4'h0;
        end
      end else if (txCnt_q != 12'h000) begin
        txCnt_q <= txCnt_q - 12'h001;
      end else if (txBit_q == 4'ha) begin
        txBusy <= 1'b0;
      end else begin
        txd     <= txSh_q[0];
        txSh_q  <= {1'b1, txSh_q[9:1]};
        txBit_q <= txBit_q + 4'h1;
        txCnt_q <= divisor - 12'h001;
      end
    end
  end

endmodule

// *** sim/mhsl_host.sv ***
`timescale 1ns/1ps
// ----------------
// host serial side
// ----------------
module mhsl_host
  import mhsl_pkg::*;
(
  mclk,
  rxd,
  txd
);
  input  wire logic mclk;
  output logic      rxd;
  input  wire logic txd;
  localparam int BIT = int'(DIV_HI);
  logic [7:0] rxq[$];

  // whole frames only, no filler bytes; call at a rising edge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge mclk);
    end
  endtask

  // mid-bit sampling so edge jitter of a few clocks is harmless
  initial begin
    rxd = 1'b1;
    forever begin
      logic [7:0] b;
      @(negedge txd);
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge mclk);
      rxq.push_back(b);
    end
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin testsRun++; if ((a) !== (e)) begin errors++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
  import mhsl_pkg::*;
  // ------------
  // bench set-up
  // ------------
  localparam int TO = 8000;  // above one byte time, else every write would expire
  logic        mclk, sysRst, hwRstLow, purgeLow, pulseInit, rxd, txd, dataReadyLow, psel, penable, pwrite;
  logic        pready, pslverr, overflowEvt, postBusy, pulsePolarity, low, ceIn, rateSel;
  logic [4:0]  meterEvt;
  logic [7:0]  paddr;
  logic [15:0] rawTemp, tempOffset;
  logic [31:0] pwdata, prdata, energyIn, setupWord, rd;
  int          errors, testsRun, cyc, seed, stat, setup, nom, ev;

  // rate strap fixed high for the whole run, so no purge is owed for it
  mhsl_link #(.RX_TO_CYC(TO), .IVL_CYC(50)) DUT (
    .mclk(mclk), .sys_rst(sysRst), .ce(ceIn), .hardwareResetLow(hwRstLow), .linkPurgeLow(purgeLow),
    .rateSelectInput(rateSel), .pulseInitInput(pulseInit), .rxd(rxd), .txd(txd), .dataReadyLow(dataReadyLow),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .energyIn(energyIn), .overflowEvt(overflowEvt), .meterEvt(meterEvt),
    .postBusy(postBusy), .rawTemp(rawTemp), .setupWord(setupWord), .tempOffset(tempOffset),
    .pulsePolarity(pulsePolarity));
  mhsl_host host (.mclk(mclk), .rxd(rxd), .txd(txd));

  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 99000) begin
      errors++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d errors %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // apb cycle: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input int e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask

  // -------------
  // main sequence
  // -------------
  initial begin
    seed = 32'hef4e895d;
    {sysRst, hwRstLow, purgeLow, psel, penable, pwrite, overflowEvt, postBusy} = 8'hf0;
    {paddr, pwdata, meterEvt} = '0;
    {ceIn, rateSel} = 2'b11;
    pulseInit = 1'($random(seed));
    energyIn = $random(seed);
    rawTemp = 16'($random(seed));
    repeat (12) @(posedge mclk);
    sysRst <= 1'b0;
    `CHK("polarity", pulseInit, pulsePolarity)
    rdchk(A_STATUS, 2, "status rst");
    ev = $random(seed) & 31;
    @(posedge mclk);
    overflowEvt <= 1'b1;
    meterEvt <= 5'(ev);
    @(posedge mclk);
    overflowEvt <= 1'b0;
    meterEvt <= 5'h00;
    rdchk(A_STATUS, 6 | (ev << 3), "events");
    apb(1'b1, A_STATUS, 32'hff);
    apb(1'b0, 8'h40, 32'h0);
    nom = $random(seed) & 16'hffff;
    apb(1'b1, A_NOMTEMP, nom);
    repeat (2) @(posedge mclk);
    `CHK("temp", 16'(rawTemp - nom), tempOffset)
    // clock enable low must freeze the compensation term
    ceIn <= 1'b0;
    rawTemp <= rawTemp + 16'h0001;
    repeat (3) @(posedge mclk);
    `CHK("frozen", 16'(rawTemp - 16'h0001 - nom), tempOffset)
    ceIn <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("thawed", 16'(rawTemp - nom), tempOffset)
    setup = $random(seed) & 32'h06c000e0;
    apb(1'b1, A_SETUP, setup);
    @(posedge mclk);
    `CHK("setup", setup, setupWord)
    // broken write: short gap keeps the command, long gap drops it
    host.send(8'h81);
    host.send(8'h12);
    repeat (TO / 2) @(posedge mclk);
    rdchk(A_STATUS, 0, "no expiry");
    repeat (TO) @(posedge mclk);
    rdchk(A_STATUS, 2, "expiry");
    apb(1'b1, A_STATUS, 32'hff);
    host.send(8'h81);
    purgeLow <= 1'b0;
    @(posedge mclk);
    purgeLow <= 1'b1;
    repeat (TO + TO / 2) @(posedge mclk);
    rdchk(A_STATUS, 0, "purged");
    `CHK("setup kept", setup, setupWord)
    // status read answered only after post-processing ends
    @(posedge mclk);
    overflowEvt <= 1'b1;
    postBusy <= 1'b1;
    @(posedge mclk);
    overflowEvt <= 1'b0;
    stat = 4;
    host.send(8'h01);
    repeat (1000) @(posedge mclk);
    `CHK("held", 0, host.rxq.size())
    postBusy <= 1'b0;
    wait (host.rxq.size() == 4);
    for (int i = 3; i >= 0; i--) begin
      rd[7:0] = host.rxq.pop_front();
      `CHK("serial", 8'(stat >> (8 * i)), rd[7:0])
    end
    // data-ready: arm with an energy read, then fall, then release
    apb(1'b1, A_MASK, 32'h1);
    apb(1'b1, A_INTERVAL, 32'h4);
    apb(1'b1, A_SETUP, setup | 32'h210);
    apb(1'b0, A_ENERGY, 32'h0);
    for (int k = 0; k < 1000 && dataReadyLow !== 1'b0; k++) @(posedge mclk);
    `CHK("ready low", 1'b0, dataReadyLow)
    rdchk(A_ENERGY, energyIn, "energy");
    repeat (2) @(posedge mclk);
    `CHK("ready high", 1'b1, dataReadyLow)
    apb(1'b1, A_MASK, 32'h0);
    apb(1'b0, A_ENERGY, 32'h0);
    low = 1'b0;
    repeat (500) @(posedge mclk) low |= !dataReadyLow;
    `CHK("masked", 1'b0, low)
    hwRstLow <= 1'b0;
    @(posedge mclk);
    hwRstLow <= 1'b1;
    @(posedge mclk);
    `CHK("hw reset", 0, setupWord)
    rdchk(A_STATUS, 2, "hw status");
    print_verdict();
  end
endmodule
